// ===== rtl/homing_params.svh
// Constants of the speech decoder homing block.
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH

// Samples per output speech frame and the encoder homing sample value.
`define FRAME_SAMPLES 8'hA0
`define HOME_SAMPLE 16'h0008

// Parameter bits per frame for each of the eight codec modes.
`define FRAME_LEN_M0 8'h5F
`define FRAME_LEN_M1 8'h67
`define FRAME_LEN_M2 8'h76
`define FRAME_LEN_M3 8'h86
`define FRAME_LEN_M4 8'h94
`define FRAME_LEN_M5 8'h9F
`define FRAME_LEN_M6 8'hCC
`define FRAME_LEN_M7 8'hF4

// Bits covering the LPC and first-subframe parameters for modes 0 to 2; modes 3 to 7 hold their full frame length.
`define PREFIX_LEN_M0 8'h30
`define PREFIX_LEN_M1 8'h2E
`define PREFIX_LEN_M2 8'h33
`define PREFIX_LEN_M3 8'h86
`define PREFIX_LEN_M4 8'h94
`define PREFIX_LEN_M5 8'h9F
`define PREFIX_LEN_M6 8'hCC
`define PREFIX_LEN_M7 8'hF4

// Reference store geometry: eight modes of 256 bit slots each.
`define REF_ADDR_W 11
`define REF_BITS_TOTAL 2048

`endif

// ===== rtl/homing_pkg.sv
// Types shared by the speech decoder homing block.
package homing_pkg;

    typedef logic [2:0] mode_type;
    typedef logic [15:0] sample_type;
    typedef logic [7:0] count_type;

    typedef enum logic [3:0] {
        ST_RECV = 4'h1,
        ST_EVAL = 4'h2,
        ST_PLAY = 4'h4,
        ST_HOME = 4'h8
    } state_type;

endpackage

// ===== rtl/homing_ref_rom.sv
// Reference homing parameter frames, one bit per read, registered output.
`timescale 1ns/1ps
`include "homing_params.svh"

module homing_ref_rom #(
    parameter logic [`REF_BITS_TOTAL-1:0] REF_BITS = '0
) (
    input wire logic ref_clk,
    input wire logic [`REF_ADDR_W-1:0] rd_addr,
    output logic rd_bit
);

    // Read data leaves through a flip-flop so the compare path stays short.
    always_ff @(posedge ref_clk) begin
        rd_bit <= REF_BITS[rd_addr];
    end

endmodule // homing_ref_rom

// ===== rtl/speech_decoder_homing.sv
// Homing control of a speech decoder: detection, substitution, state reset.
//
// Contract
// - Home only on active-mode homing frame; decode normally.
// - Home at start and homing frame in: output encoder homing frame.
// - After homing frame reset all state, noise generator.
// - Next frame starts from restored home state.
// - In home state compare LPC, subframe one only; modes three and up compare the whole frame.
// - Encoder homing frame: 160 samples of 0008.
// - Eight references; pick the active mode's one.
`timescale 1ns/1ps
`include "homing_params.svh"

module speech_decoder_homing #(
    parameter logic [`REF_BITS_TOTAL-1:0] REF_BITS = '0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire homing_pkg::mode_type mode_in,
    input wire logic param_valid,
    input wire logic param_first,
    input wire logic param_bit,
    output logic param_ready,
    output logic decode_go,
    output logic home_state_rst,
    input wire logic syn_valid,
    input wire homing_pkg::sample_type syn_sample,
    output logic out_valid,
    output homing_pkg::sample_type out_sample,
    output logic home_flag,
    output logic homing_seen
);
    import homing_pkg::*;

    // The whole block state is one record, computed in one process and
    // registered in another. Keeping it in one place means reset can
    // never leave a field behind in a stale value.
    typedef struct packed {
        state_type st;
        mode_type mode;
        count_type bit_cnt;
        count_type samp_cnt;
        logic cmp_valid;
        logic cmp_bit;
        count_type cmp_idx;
        logic mismatch;
        logic was_home;
        logic subst;
        logic home;
        logic seen;
        logic go;
        logic hrst;
        logic ovalid;
        sample_type osample;
    } hstate_type;

    // Decode helpers around the state record; none of them hold state.
    // The counters are eight bits, enough for the longest frame.
    hstate_type s_r;
    hstate_type s_nxt;
    logic take;
    logic rom_bit;
    mode_type rd_mode;
    count_type rd_idx;
    count_type len_full;
    count_type len_prefix;
    count_type cmp_limit;

    // Frame length of the mode latched for the current frame.
    // Lengths differ per mode, so the end of a frame is found by count.
    function automatic count_type frame_len(input mode_type m);
        case (m)
            3'h0: frame_len = `FRAME_LEN_M0;
            3'h1: frame_len = `FRAME_LEN_M1;
            3'h2: frame_len = `FRAME_LEN_M2;
            3'h3: frame_len = `FRAME_LEN_M3;
            3'h4: frame_len = `FRAME_LEN_M4;
            3'h5: frame_len = `FRAME_LEN_M5;
            3'h6: frame_len = `FRAME_LEN_M6;
            default: frame_len = `FRAME_LEN_M7;
        endcase
    endfunction

    // Bits of LPC and first subframe; later bits may be skipped at home.
    // Modes three and up list their full length, so they never cut early.
    function automatic count_type prefix_len(input mode_type m);
        case (m)
            3'h0: prefix_len = `PREFIX_LEN_M0;
            3'h1: prefix_len = `PREFIX_LEN_M1;
            3'h2: prefix_len = `PREFIX_LEN_M2;
            3'h3: prefix_len = `PREFIX_LEN_M3;
            3'h4: prefix_len = `PREFIX_LEN_M4;
            3'h5: prefix_len = `PREFIX_LEN_M5;
            3'h6: prefix_len = `PREFIX_LEN_M6;
            default: prefix_len = `PREFIX_LEN_M7;
        endcase
    endfunction

    // Ready is combinational but depends on state only, never on valid.
    // Parameter bits are only taken while receiving, so nothing of the
    // next frame can reach the core before its state has been homed.
    assign param_ready = (s_r.st == ST_RECV);
    assign take = param_valid && param_ready;

    // The first bit of a frame addresses the reference of the new mode.
    // The reference read goes out in the same cycle as the take, so the
    // registered read bit meets the registered input bit one cycle on.
    assign rd_mode = (take && param_first) ? mode_in : s_r.mode;
    assign rd_idx = (take && param_first) ? 8'h00 : s_r.bit_cnt;
    // Lengths follow the latched mode, not the live mode input.
    assign len_full = frame_len(s_r.mode);
    assign len_prefix = prefix_len(s_r.mode);
    // A home-state decoder needs only the prefix to decide early.
    assign cmp_limit = s_r.was_home ? len_prefix : len_full;

    // One reference frame per mode; the address is mode above bit index.
    // Slots past a mode's length are never addressed by a legal frame.
    homing_ref_rom #(
        .REF_BITS(REF_BITS)
    ) u_ref_rom (
        .ref_clk(ref_clk),
        .rd_addr({rd_mode, rd_idx}),
        .rd_bit(rom_bit)
    );

    // Next-state logic of the whole block.
    always_comb begin
        s_nxt = s_r;
        // Pulses default low; each is raised for exactly one cycle.
        s_nxt.go = 1'b0;
        s_nxt.hrst = 1'b0;
        s_nxt.ovalid = 1'b0;
        // Capture this cycle's take for the compare one cycle later.
        s_nxt.cmp_valid = take;
        s_nxt.cmp_bit = param_bit;
        s_nxt.cmp_idx = rd_idx;
        // The compare runs one cycle behind the take, matching rom latency.
        // A mismatch is sticky until the first bit of the next frame.
        if (s_r.cmp_valid && (s_r.cmp_idx < cmp_limit) &&
                (s_r.cmp_bit != rom_bit)) begin
            s_nxt.mismatch = 1'b1;
        end
        case (s_r.st)
            ST_RECV: begin
                // Bits may come back to back; the last one ends the frame.
                if (take) begin
                    if (param_first) begin
                        s_nxt.mode = mode_in;
                        s_nxt.bit_cnt = 8'h01;
                        s_nxt.mismatch = 1'b0;
                        // Home flag at frame start picks the output.
                        s_nxt.was_home = s_r.home;
                    end else begin
                        s_nxt.bit_cnt = s_r.bit_cnt + 8'h01;
                    end
                    if (rd_idx == frame_len(rd_mode) - 8'h01) begin
                        s_nxt.st = ST_EVAL;
                    end
                end
            end
            ST_EVAL: begin
                // Last compare lands here; decide and start normal decoding.
                // Reads s_nxt so that this final compare still counts.
                s_nxt.seen = ~s_nxt.mismatch;
                s_nxt.subst = ~s_nxt.mismatch && s_r.was_home;
                s_nxt.go = 1'b1;
                s_nxt.samp_cnt = 8'h00;
                s_nxt.st = ST_PLAY;
            end
            ST_PLAY: begin
                // The core sets the pace and has no backpressure, so each
                // sample is passed on in the cycle after it arrives.
                if (syn_valid) begin
                    s_nxt.ovalid = 1'b1;
                    // Synthesized speech is dropped for the fixed pattern.
                    s_nxt.osample = s_r.subst ? `HOME_SAMPLE
                                              : syn_sample;
                    s_nxt.samp_cnt = s_r.samp_cnt + 8'h01;
                    if (s_r.samp_cnt == `FRAME_SAMPLES - 8'h01) begin
                        s_nxt.st = ST_HOME;
                    end
                end
            end
            ST_HOME: begin
                // Homing happens only after the frame has fully played out.
                // A frame that was not homing clears the flag right here.
                s_nxt.hrst = s_r.seen;
                s_nxt.home = s_r.seen;
                s_nxt.st = ST_RECV;
            end
            default: begin
                // An illegal state code falls back to receiving.
                s_nxt.st = ST_RECV;
            end
        endcase
    end

    // State register; reset puts the decoder in its home state.
    // Reset is synchronous, so the record has a single clocked writer.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_r <= '{st: ST_RECV, mode: 3'h0, bit_cnt: 8'h00,
                     samp_cnt: 8'h00, cmp_valid: 1'b0, cmp_bit: 1'b0,
                     cmp_idx: 8'h00, mismatch: 1'b0, was_home: 1'b1,
                     subst: 1'b0, home: 1'b1, seen: 1'b0, go: 1'b0,
                     hrst: 1'b0, ovalid: 1'b0,
                     osample: 16'h0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output is a field of the registered record, so none of them
    // can glitch; only ready above is combinational.
    assign decode_go = s_r.go;
    assign home_state_rst = s_r.hrst;
    assign out_valid = s_r.ovalid;
    assign out_sample = s_r.osample;
    assign home_flag = s_r.home;
    assign homing_seen = s_r.seen;

endmodule // speech_decoder_homing

// ===== sim/homing_checker_assertions.sv
// Port checks for the homing control.
`timescale 1ns/1ps
module homing_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic param_ready,
    input wire logic decode_go,
    input wire logic home_state_rst,
    input wire logic syn_valid,
    input wire homing_pkg::sample_type syn_sample,
    input wire logic out_valid,
    input wire homing_pkg::sample_type out_sample,
    input wire logic home_flag,
    input wire logic homing_seen
);
    import homing_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // The receiver must stay shut for three cycles from the decode start.
    sequence stall_s;
        !param_ready [*3];
    endsequence
    sequence reopen_s;
        home_state_rst ##1 param_ready;
    endsequence
    ready_closed_a: assert property (decode_go |-> stall_s)
        else $error("receiver open in playback");
    go_pulse_a: assert property (decode_go |=> !decode_go)
        else $error("decode start too long");
    echo_time_a: assert property (out_valid |-> $past(syn_valid))
        else $error("output without sample");
    home_word_a: assert property (out_valid && homing_seen && home_flag
        |-> out_sample == 16'h0008)
        else $error("home word wrong");
    pass_thru_a: assert property (out_valid && !(homing_seen && home_flag)
        |-> out_sample == $past(syn_sample))
        else $error("sample not passed");
    rst_cause_a: assert property (home_state_rst |-> homing_seen)
        else $error("state reset without homing");
    reopen_a: assert property (home_state_rst |-> reopen_s)
        else $error("receiver not reopened");
    flag_fall_a: assert property ($fell(home_flag) |-> !homing_seen)
        else $error("home flag lost on homing");
    flag_rise_a: assert property ($rose(home_flag) |-> home_state_rst)
        else $error("home flag set without reset");
endmodule // homing_checker
bind speech_decoder_homing homing_checker chk (.ref_clk, .sys_rst,
    .param_ready, .decode_go, .home_state_rst, .syn_valid, .syn_sample,
    .out_valid, .out_sample, .home_flag, .homing_seen);

// ===== sim/frame_source.sv
// Channel-side model sending one parameter frame bit by bit.
`timescale 1ns/1ps
module frame_source (
    input wire logic ref_clk,
    input wire logic param_ready,
    output homing_pkg::mode_type mode_in,
    output logic param_valid,
    output logic param_first,
    output logic param_bit
);
    import homing_pkg::*;
    int lens[8] = '{95, 103, 118, 134, 148, 159, 204, 244};
    initial begin
        mode_in = '0;
        param_valid = 1'b0;
        param_first = 1'b0;
        param_bit = 1'b0;
    end
    // A bit is held until the receiver takes it; idle line shows inverse.
    task automatic send(input mode_type m, input logic home,
                        input logic [15:0] pat, input int skip);
        logic rdy;
        mode_in = m;
        for (int i = 0; i < lens[m]; i++) begin
            param_valid = 1'b1;
            param_first = (i == 0);
            // Ordinary frames differ in their first bit; a nonzero skip
            // keeps the prefix equal to probe the short home compare.
            param_bit = (home || i < skip) ? 1'b0 : pat[i % 16];
            // Ready is sampled before the edge, as the receiver sees it.
            do begin
                rdy = param_ready;
                @(posedge ref_clk);
            end while (rdy !== 1'b1);
            #1;
        end
        param_valid = 1'b0;
        param_first = 1'b0;
        param_bit = ~param_bit;
    endtask
endmodule // frame_source

// ===== sim/testbench.sv
// Self-checking bench for the decoder homing control.
`timescale 1ns/1ps
module testbench;
    import homing_pkg::*;
    logic ref_clk, sys_rst, param_valid, param_first, param_bit;
    logic param_ready, decode_go, home_state_rst, syn_valid, out_valid;
    logic home_flag, homing_seen, rst_seen;
    logic exp_flag = 1'b1;
    mode_type mode_in;
    sample_type syn_sample, out_sample, exp_s;
    logic [15:0] rnd = 16'hC8B2;
    int mismatches = 0;
    int total_checks = 0;
    speech_decoder_homing dut (.ref_clk, .sys_rst, .mode_in, .param_valid,
        .param_first, .param_bit, .param_ready, .decode_go, .home_state_rst,
        .syn_valid, .syn_sample, .out_valid, .out_sample, .home_flag,
        .homing_seen);
    frame_source src (.ref_clk, .param_ready, .mode_in, .param_valid,
        .param_first, .param_bit);
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One frame in, 160 samples out; substitution follows the flag.
    // A nonzero skip sends a frame equal only in its first bits; at home
    // such a frame counts as homing in the three short-prefix modes.
    task automatic run_frame(input mode_type m, input logic home,
                             input int skip);
        int k;
        logic hit;
        logic subst;
        hit = home || (skip > 0 && exp_flag && m < 3'h3);
        subst = hit & exp_flag;
        rnd = lfsr_next(rnd);
        src.send(m, home, rnd | 16'h0001, skip);
        k = 0;
        while (decode_go !== 1'b1 && k < 8) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        check("decode_go", decode_go, 1'b1);
        check("homing_seen", homing_seen, hit);
        for (int i = 0; i < 160; i++) begin
            rnd = lfsr_next(rnd);
            syn_valid = 1'b1;
            syn_sample = rnd;
            exp_s = subst ? 16'h0008 : rnd;
            @(posedge ref_clk);
            #1;
            check("out_valid", out_valid, 1'b1);
            check("out_sample", out_sample, exp_s);
        end
        syn_valid = 1'b0;
        rst_seen = 1'b0;
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            rst_seen |= home_state_rst;
        end
        exp_flag = hit;
        check("state_rst", rst_seen, hit);
        check("home_flag", home_flag, exp_flag);
        check("ready", param_ready, 1'b1);
        $display("frame mode %0d home %0d done", m, home);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Corner frames first, then every mode, then random traffic.
    initial begin
        sys_rst = 1'b1;
        syn_valid = 1'b0;
        syn_sample = '0;
        repeat (5) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        check("flag_rst", home_flag, 1'b1);
        run_frame(3'h0, 1'b1, 0);
        run_frame(3'h3, 1'b0, 0);
        run_frame(3'h3, 1'b1, 0);
        run_frame(3'h3, 1'b1, 0);
        // Tail-only frames: short compare at home in modes below three, full compare otherwise.
        run_frame(3'h1, 1'b0, 64);
        run_frame(3'h3, 1'b0, 64);
        run_frame(3'h2, 1'b0, 64);
        // A reset in mid-run must bring the home state back.
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        exp_flag = 1'b1;
        check("flag_rst", home_flag, 1'b1);
        run_frame(3'h3, 1'b1, 0);
        for (int m = 0; m < 8; m++) run_frame(m[2:0], 1'b1, 0);
        repeat (10) begin
            rnd = lfsr_next(rnd);
            run_frame(rnd[2:0], rnd[5], 0);
        end
        complete_run();
    end
    // Watchdog: a hang counts as a mismatch and ends the run the same way.
    initial begin
        #2ms;
        mismatches++;
        complete_run();
    end
endmodule // testbench
